/* File: hdl/sld_driver.sv */
// segment display driver: serial input, latch, common and segment waveforms
//
// What this block does
// - each serial clock rise shifts data into a 160-stage shift register
// - a one bit lights its segment, zero darkens it, one to one
// - half cascade output always shows shift stage 80
// - full cascade output always shows shift stage 160
// - latch follows the shift register while load is high
// - latch holds last captured data while load is low
// - oscillator divided by eight in static, four in half duty, gives common
// - external source select makes oscillator input the common phase
// - duty select high means half duty with two backplanes, low static
// - expander use: oscillator input high inverts all segment outputs
// - static mode: both backplanes pulse high and low with common phase
// - half duty: backplanes alternate, exactly one selected at a time
// - selected backplane follows common high and low, other sits middle
// - half duty: first backplane shows bits 1-80, second 81-160
// - static mode uses first latch half only
// - lit segment inverts the common signal, dark segment follows it
// - all-on test lights every segment and overrides all-off
// - all-off darkens every segment unless all-on test is high
// - half duty cascades share an open-drain line aligning backplane phase
`timescale 1ns/1ps
`default_nettype none
`include "sld_regs.svh"

module sld_driver
#(
    parameter int unsigned OSC_HALF_CYCLES = `SLD_CLK_HZ / (2 * `SLD_OSC_HZ)
)
(
    input  wire logic                       clock,              // 200 MHz core clock
    input  wire logic                       nrst,               // async reset, active low
    input  wire logic                       ce,                 // freezes all state when low
    // serial display interface
    input  wire logic                       serialClock,        // serial clock pin
    input  wire logic                       serialData,         // serial data pin
    input  wire logic                       loadLevel,          // latch load pin
    output logic                            cascadeOutHalf,     // stage 80 for chaining
    output logic                            cascadeOutFull,     // stage 160 for chaining
    // mode and test pins
    input  wire logic                       dutySelect,         // high: half duty
    input  wire logic                       commonSourceSelect, // high: external common
    input  wire logic                       oscillatorInput,    // external common or polarity
    input  wire logic                       allOnTest,          // light every segment
    input  wire logic                       allOff,             // blank every segment
    // oscillator and common
    output logic                            oscillatorDrive,    // internal oscillator level
    output logic                            commonPhaseOut,     // common phase for slaves
    // phase alignment line, open drain
    input  wire logic                       syncLineIn,         // line level
    output logic                            syncLineOut,        // always low when driven
    output logic                            syncLineOe,         // high while pulling low
    // output stage codes
    output sld_pkg::sld_level_t             backplaneFirst,     // first backplane level
    output sld_pkg::sld_level_t             backplaneSecond,    // second backplane level
    output logic        [`SLD_SEGS-1:0]     segmentOutputs,     // 1: high, 0: low
    // apb slave
    input  wire logic                       psel,               // select
    input  wire logic                       penable,            // access phase
    input  wire logic                       pwrite,             // write
    input  wire logic   [`SLD_ADDR_W-1:0]   paddr,              // byte address
    input  wire logic   [31:0]              pwdata,             // write data
    output logic        [31:0]              prdata,             // read data, registered
    output logic                            pready,             // ready
    output logic                            pslverr             // unmapped address
);

    // ==========================================================
    // state and wiring
    sld_pkg::sld_top_t          s_q;
    sld_pkg::sld_top_t          s_d;
    logic [`SLD_SYNC_W-1:0]     pinRaw;
    logic [`SLD_SYNC_W-1:0]     pinSync;
    logic [`SLD_STAGES-1:0]     latch;
    logic                       shiftEn;
    logic                       oscTick;
    logic                       comNext;
    logic                       comRise;
    logic                       syncFall;
    logic                       blankEff;
    logic                       testEff;
    logic                       apbSetup;
    logic                       apbWrite;
    logic                       addrHit;

    localparam logic [`SLD_OSC_CNT_W-1:0] OscLast = `SLD_OSC_CNT_W'(OSC_HALF_CYCLES - 1);
    // divider taps: bit 2 for /8, bit 1 for /4
    localparam int DivStaticBit = $clog2(`SLD_DIV_STATIC) - 1;
    localparam int DivHalfBit   = $clog2(`SLD_DIV_HALF) - 1;

    // ==========================================================
    // pin synchroniser, every asynchronous pin passes two flops
    assign pinRaw = {syncLineIn, allOff, allOnTest, oscillatorInput, commonSourceSelect,
                     dutySelect, loadLevel, serialData, serialClock};

    sld_sync u_sync
    (
        .clock  (clock),
        .nrst   (nrst),
        .ce     (ce),
        .pinIn  (pinRaw),
        .pinOut (pinSync)
    );

    // serial clock rise seen on the synchronised copy only
    assign shiftEn = pinSync[`SLD_PIN_SCLK] & ~s_q.serClkD;

    // ==========================================================
    // shift register and latch
    sld_store u_store
    (
        .clock   (clock),
        .nrst    (nrst),
        .ce      (ce),
        .shiftEn (shiftEn),
        .dataIn  (pinSync[`SLD_PIN_SDATA]),
        .loadLvl (pinSync[`SLD_PIN_LOAD]),
        .latch   (latch),
        .tapHalf (cascadeOutHalf),
        .tapFull (cascadeOutFull)
    );

    // ==========================================================
    // address decode, used by both read and write paths
    function automatic logic isAddr(input logic [`SLD_ADDR_W-1:0] a,
                                    input logic [31:0] off);
        isAddr = (a == off[`SLD_ADDR_W-1:0]);
    endfunction

    // segment level for one display bit against the common phase
    function automatic logic segLevel(input logic lit, input logic com);
        segLevel = lit ? ~com : com;
    endfunction

    // backplane level while selected
    function automatic sld_pkg::sld_level_t bpLevel(input logic com);
        bpLevel = com ? sld_pkg::SLD_LVL_HIGH : sld_pkg::SLD_LVL_LOW;
    endfunction

    assign addrHit  = isAddr(paddr, `SLD_OFF_CTRL) | isAddr(paddr, `SLD_OFF_STATUS);
    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pwrite & ce;

    // test overrides: software bits or the pins, all-on always wins
    assign testEff  = pinSync[`SLD_PIN_TEST] | s_q.ctrl[`SLD_CTRL_TEST_BIT];
    assign blankEff = (pinSync[`SLD_PIN_BLANK] | s_q.ctrl[`SLD_CTRL_BLANK_BIT])
        & ~testEff;

    // ==========================================================
    // next-state logic
    always_comb
    begin
        s_d      = s_q;
        oscTick  = 1'b0;
        comNext  = 1'b0;
        comRise  = 1'b0;
        syncFall = 1'b0;

        // mode pins are levels; keep one registered copy for the outputs
        s_d.dutyQ   = pinSync[`SLD_PIN_DUTY];
        s_d.extQ    = pinSync[`SLD_PIN_EXT];
        s_d.serClkD = pinSync[`SLD_PIN_SCLK];

        // internal oscillator stands in for the external rc network
        if (s_q.oscCnt == OscLast)
        begin
            s_d.oscCnt = '0;
            s_d.oscLvl = ~s_q.oscLvl;
            oscTick    = ~s_q.oscLvl;
        end
        else
        begin
            s_d.oscCnt = s_q.oscCnt + `SLD_OSC_CNT_W'(1);
        end

        // divider runs on each oscillator period
        if (oscTick)
            s_d.divCnt = s_q.divCnt + `SLD_DIV_W'(1);

        // common phase: external input buffered, or divided oscillator
        if (s_q.extQ)
            comNext = pinSync[`SLD_PIN_OSC];
        else if (s_q.dutyQ)
            comNext = s_q.divCnt[DivHalfBit];
        else
            comNext = s_q.divCnt[DivStaticBit];
        s_d.comPh = comNext;
        comRise   = comNext & ~s_q.comPh;

        // phase alignment line: a falling level forces the second backplane
        s_d.syncD = pinSync[`SLD_PIN_SYNC];
        syncFall  = s_q.syncD & ~pinSync[`SLD_PIN_SYNC];
        s_d.syncPull = 1'b0;
        if (!s_q.dutyQ)
            s_d.selSecond = 1'b0;
        else if (syncFall)
            s_d.selSecond = 1'b1;
        else if (comRise)
        begin
            s_d.selSecond = ~s_q.selSecond;
            s_d.syncPull  = ~s_q.selSecond;
        end

        // backplane codes
        if (!s_q.dutyQ)
        begin
            s_d.bpFirst  = bpLevel(s_q.comPh);
            s_d.bpSecond = bpLevel(s_q.comPh);
        end
        else if (s_q.selSecond)
        begin
            s_d.bpFirst  = sld_pkg::SLD_LVL_MID;
            s_d.bpSecond = bpLevel(s_q.comPh);
        end
        else
        begin
            s_d.bpFirst  = bpLevel(s_q.comPh);
            s_d.bpSecond = sld_pkg::SLD_LVL_MID;
        end

        // segment codes: latch half picked by the selected backplane
        for (int n = 0; n < `SLD_SEGS; n++)
        begin
            s_d.seg[n] = segLevel(testEff | (~blankEff &
                         (s_q.dutyQ && s_q.selSecond ? latch[n + `SLD_SEGS] : latch[n])),
                         s_q.comPh);
        end

        // apb: write in access phase, read data prepared in setup
        if (apbWrite && isAddr(paddr, `SLD_OFF_CTRL))
            s_d.ctrl = pwdata[1:0];
        if (apbSetup)
        begin
            // spare and unmapped bits read zero
            s_d.prdata = 32'h0000_0000;
            if (isAddr(paddr, `SLD_OFF_CTRL))
                s_d.prdata[1:0] = s_q.ctrl;
            else if (isAddr(paddr, `SLD_OFF_STATUS))
            begin
                s_d.prdata[`SLD_ST_DUTY_BIT] = s_q.dutyQ;
                s_d.prdata[`SLD_ST_EXT_BIT]  = s_q.extQ;
                s_d.prdata[`SLD_ST_COM_BIT]  = s_q.comPh;
                s_d.prdata[`SLD_ST_SEL_BIT]  = s_q.selSecond;
                s_d.prdata[`SLD_ST_HALF_BIT] = cascadeOutHalf;
                s_d.prdata[`SLD_ST_FULL_BIT] = cascadeOutFull;
            end
        end
    end

    // ==========================================================
    // state register; reset puts both backplanes and segments low
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q      <= '0;
            s_q.ctrl <= `SLD_CTRL_RESET;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // outputs
    assign oscillatorDrive = s_q.oscLvl;
    assign commonPhaseOut  = s_q.comPh;
    assign syncLineOut     = 1'b0;
    assign syncLineOe      = s_q.syncPull;
    assign backplaneFirst  = s_q.bpFirst;
    assign backplaneSecond = s_q.bpSecond;
    assign segmentOutputs  = s_q.seg;
    assign prdata          = s_q.prdata;
    // zero wait states; a frozen block holds the master off
    assign pready          = ce;
    assign pslverr         = psel & penable & ~addrHit;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence sModeSteady;
        ce && $past(ce) && $stable(s_q.dutyQ);
    endsequence

    a_common_ext: assert property (
        ce && s_q.extQ
        |=> s_q.comPh == $past(pinSync[`SLD_PIN_OSC]))
        else $error("external common not passed to common output");

    a_div_static: assert property (
        ce && !s_q.extQ && !s_q.dutyQ && s_q.divCnt == 3'h3 && oscTick
        |=> ##1 commonPhaseOut)
        else $error("static common not divided by eight");

    a_static_bp: assert property (
        sModeSteady ##0 !$past(s_q.dutyQ) |->
        backplaneFirst == bpLevel($past(s_q.comPh))
        && backplaneSecond == backplaneFirst)
        else $error("static backplanes not in phase with common");

    a_one_select: assert property (
        sModeSteady ##0 $past(s_q.dutyQ) |->
        (backplaneFirst == sld_pkg::SLD_LVL_MID)
        != (backplaneSecond == sld_pkg::SLD_LVL_MID))
        else $error("half duty needs exactly one selected backplane");

    a_sel_alternate: assert property (
        ce && s_q.dutyQ && comRise && !syncFall
        |=> s_q.selSecond != $past(s_q.selSecond))
        else $error("backplane selection did not alternate");

    a_test_on: assert property (
        ce && testEff
        |=> segmentOutputs == {`SLD_SEGS{~$past(s_q.comPh)}})
        else $error("all-on test did not light every segment");

    a_blank_off: assert property (
        ce && blankEff |=> segmentOutputs == {`SLD_SEGS{$past(s_q.comPh)}})
        else $error("all-off did not darken every segment");

    a_static_half: assert property (
        ce && !s_q.dutyQ && !testEff && !blankEff |=>
        segmentOutputs == ($past(latch[`SLD_SEGS-1:0])
        ^ {`SLD_SEGS{$past(s_q.comPh)}}))
        else $error("static segments not from first latch half");

    a_sync_pull: assert property (
        ce && s_q.dutyQ && comRise && !s_q.selSecond && !syncFall
        |=> syncLineOe ##1 !syncLineOe)
        else $error("alignment pulse not one cycle");

    a_osc_toggle: assert property (
        ce && s_q.oscCnt == OscLast |=> oscillatorDrive != $past(oscillatorDrive))
        else $error("oscillator level did not toggle");

endmodule // sld_driver

`default_nettype wire

/* File: hdl/sld_regs.svh */
// constants of the segment display driver: sizes, pin positions, offsets, timing
`ifndef SLD_REGS_SVH
`define SLD_REGS_SVH

// ==========================================================
// storage sizes
`define SLD_STAGES          160
`define SLD_SEGS            80
`define SLD_SYNC_W          9
`define SLD_OSC_CNT_W       24
`define SLD_DIV_W           3

// ==========================================================
// synchroniser bit positions of the pins
`define SLD_PIN_SCLK        0
`define SLD_PIN_SDATA       1
`define SLD_PIN_LOAD        2
`define SLD_PIN_DUTY        3
`define SLD_PIN_EXT         4
`define SLD_PIN_OSC         5
`define SLD_PIN_TEST        6
`define SLD_PIN_BLANK       7
`define SLD_PIN_SYNC        8

// ==========================================================
// timing: core clock, internal oscillator, divide ratios
`define SLD_CLK_HZ          200_000_000
`define SLD_OSC_HZ          1_000
`define SLD_DIV_STATIC      8
`define SLD_DIV_HALF        4

// ==========================================================
// apb register map
`define SLD_OFF_CTRL        32'h0000_0000
`define SLD_OFF_STATUS      32'h0000_0004
`define SLD_ADDR_W          12
`define SLD_CTRL_BLANK_BIT  0
`define SLD_CTRL_TEST_BIT   1
`define SLD_CTRL_RESET      2'h0
`define SLD_ST_DUTY_BIT     0
`define SLD_ST_EXT_BIT      1
`define SLD_ST_COM_BIT      2
`define SLD_ST_SEL_BIT      3
`define SLD_ST_HALF_BIT     4
`define SLD_ST_FULL_BIT     5

`endif

/* File: hdl/sld_pkg.sv */
// types shared by the segment display driver modules
`include "sld_regs.svh"

package sld_pkg;

    // ==========================================================
    // level-select codes for the external analog output stage
    typedef enum logic [1:0]
    {
        SLD_LVL_LOW  = 2'b00,
        SLD_LVL_MID  = 2'b01,
        SLD_LVL_HIGH = 2'b10
    } sld_level_t;

    // ==========================================================
    // state of the pin synchroniser
    typedef struct packed
    {
        logic [`SLD_SYNC_W-1:0] s1;
        logic [`SLD_SYNC_W-1:0] s2;
    } sld_sync_t;

    // ==========================================================
    // state of the shift register and display latch
    typedef struct packed
    {
        logic [`SLD_STAGES-1:0] shift;
        logic [`SLD_STAGES-1:0] latch;
    } sld_store_t;

    // ==========================================================
    // state of the top level
    typedef struct packed
    {
        logic [`SLD_OSC_CNT_W-1:0] oscCnt;
        logic                      oscLvl;
        logic [`SLD_DIV_W-1:0]     divCnt;
        logic                      dutyQ;
        logic                      extQ;
        logic                      comPh;
        logic                      selSecond;
        logic                      syncD;
        logic                      syncPull;
        logic                      serClkD;
        logic [1:0]                ctrl;
        sld_level_t                bpFirst;
        sld_level_t                bpSecond;
        logic [`SLD_SEGS-1:0]      seg;
        logic [31:0]               prdata;
    } sld_top_t;

endpackage

/* File: hdl/sld_sync.sv */
// two-stage synchroniser for the asynchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "sld_regs.svh"

module sld_sync
(
    input  wire logic                   clock,   // core clock
    input  wire logic                   nrst,    // async reset, active low
    input  wire logic                   ce,      // clock enable
    input  wire logic [`SLD_SYNC_W-1:0] pinIn,   // raw pins
    output logic      [`SLD_SYNC_W-1:0] pinOut   // synchronised pins
);

    sld_pkg::sld_sync_t s_q;
    sld_pkg::sld_sync_t s_d;

    // ==========================================================
    // first stage feeds only the second stage
    always_comb
    begin
        s_d    = s_q;
        s_d.s1 = pinIn;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign pinOut = s_q.s2;

endmodule // sld_sync

`default_nettype wire

/* File: hdl/sld_store.sv */
// 160-stage shift register and 160-bit display latch
`timescale 1ns/1ps
`default_nettype none
`include "sld_regs.svh"

module sld_store
(
    input  wire logic                   clock,    // core clock
    input  wire logic                   nrst,     // async reset, active low
    input  wire logic                   ce,       // clock enable
    input  wire logic                   shiftEn,  // one-cycle serial clock rise
    input  wire logic                   dataIn,   // serial data, synchronised
    input  wire logic                   loadLvl,  // load level, synchronised
    output logic      [`SLD_STAGES-1:0] latch,    // display latch
    output logic                        tapHalf,  // stage 80
    output logic                        tapFull   // stage 160
);

    sld_pkg::sld_store_t s_q;
    sld_pkg::sld_store_t s_d;

    // ==========================================================
    // shift on each serial rise; latch follows while load is high
    always_comb
    begin
        s_d = s_q;
        if (shiftEn)
            s_d.shift = {s_q.shift[`SLD_STAGES-2:0], dataIn};
        if (loadLvl)
            s_d.latch = s_q.shift;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            s_q <= '0;
        else if (ce)
            s_q <= s_d;
    end

    assign latch   = s_q.latch;
    assign tapHalf = s_q.shift[`SLD_SEGS-1];
    assign tapFull = s_q.shift[`SLD_STAGES-1];

    // ==========================================================
    // checks
    a_shift_step: assert property (@(posedge clock) disable iff (!nrst)
        ce && shiftEn |=> s_q.shift == {$past(s_q.shift[`SLD_STAGES-2:0]), $past(dataIn)})
        else $error("shift register did not advance by one stage");
    a_tap_half: assert property (@(posedge clock) disable iff (!nrst)
        ce && shiftEn |=> tapHalf == $past(s_q.shift[`SLD_SEGS-2]))
        else $error("half cascade output not stage 80");
    a_tap_full: assert property (@(posedge clock) disable iff (!nrst)
        ce && shiftEn |=> tapFull == $past(s_q.shift[`SLD_STAGES-2]))
        else $error("full cascade output not stage 160");
    a_latch_follow: assert property (@(posedge clock) disable iff (!nrst)
        ce && loadLvl |=> latch == $past(s_q.shift))
        else $error("latch did not follow shift register");
    a_latch_hold: assert property (@(posedge clock) disable iff (!nrst)
        !loadLvl |=> $stable(latch))
        else $error("latch changed while load low");

endmodule // sld_store

`default_nettype wire

/* File: verif/sld_host_model.sv */
// host model shifting serial display bits and load strobes
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// serial master: 125 ns link clock, data changed in the low phase
module sld_host_model
(
    input  wire logic clock,       // core clock
    output logic      serialClock, // serial clock pin
    output logic      serialData,  // serial data pin
    output logic      loadLevel    // latch load pin
);
    initial
    begin
        serialClock = 1'h0;
        serialData  = 1'h0;
        loadLevel   = 1'h0;
    end
    // highest segment first; link clock stands low between frames
    task automatic send(input logic [159:0] bits, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            serialData <= bits[i];
            repeat (13) @(posedge clock);
            serialClock <= 1'h1;
            repeat (12) @(posedge clock);
            serialClock <= 1'h0;
        end
        // line not held after the frame: a stale bit must not look valid
        serialData <= ~bits[0];
    endtask
    // gap after the last clock, then load high long enough to pass the sync
    task automatic load();
        repeat (20) @(posedge clock);
        loadLevel <= 1'h1;
        repeat (10) @(posedge clock);
        loadLevel <= 1'h0;
    endtask
endmodule // sld_host_model
`default_nettype wire

/* File: verif/segment_lcd_serial_driver_tb.sv */
// self-checking bench of the segment display driver
`timescale 1ns/1ps
`default_nettype none
module segment_lcd_serial_driver_tb;
    localparam int OSCH = 4;
    logic clock = 1'h0, nrst = 1'h0, ce = 1'h1, er;
    logic serialClock, serialData, loadLevel, cascadeOutHalf, cascadeOutFull;
    logic dutySelect = 1'h0, commonSourceSelect = 1'h0, oscillatorInput = 1'h0;
    logic allOnTest = 1'h0, allOff = 1'h0, oscillatorDrive, commonPhaseOut;
    logic syncLineIn, syncLineOut, syncLineOe, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, pready, pslverr, sel2;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [79:0] segmentOutputs;
    logic [1:0] seen;
    logic [159:0] pat;
    sld_pkg::sld_level_t backplaneFirst, backplaneSecond;
    int mismatches = 0, compares = 0;
    // ==========================================================
    // clock, pulled-up alignment line, design and host
    always #2.5 clock = ~clock;
    assign syncLineIn = ~syncLineOe;
    sld_driver #(.OSC_HALF_CYCLES(OSCH)) u_dut
    (
        .clock(clock), .nrst(nrst), .ce(ce), .serialClock(serialClock),
        .serialData(serialData), .loadLevel(loadLevel), .cascadeOutHalf(cascadeOutHalf),
        .cascadeOutFull(cascadeOutFull), .dutySelect(dutySelect),
        .commonSourceSelect(commonSourceSelect), .oscillatorInput(oscillatorInput),
        .allOnTest(allOnTest), .allOff(allOff), .oscillatorDrive(oscillatorDrive),
        .commonPhaseOut(commonPhaseOut), .syncLineIn(syncLineIn), .syncLineOut(syncLineOut),
        .syncLineOe(syncLineOe), .backplaneFirst(backplaneFirst),
        .backplaneSecond(backplaneSecond), .segmentOutputs(segmentOutputs), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr)
    );
    sld_host_model u_host
    (
        .clock(clock), .serialClock(serialClock), .serialData(serialData),
        .loadLevel(loadLevel)
    );
    // ==========================================================
    // helpers: compare, bus cycle, waveform expectations
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // idle cycle after each transfer so psel is never set twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clock);
    endtask
    function automatic logic [79:0] sx(input logic [79:0] d);
        return d ^ {80{commonPhaseOut}};
    endfunction
    function automatic sld_pkg::sld_level_t lv();
        return commonPhaseOut ? sld_pkg::SLD_LVL_HIGH : sld_pkg::SLD_LVL_LOW;
    endfunction
    // wait for a common change, then let the one-cycle output lag land
    task automatic settle();
        logic c;
        c = commonPhaseOut;
        repeat (200) if (commonPhaseOut === c) @(posedge clock);
        repeat (3) @(posedge clock);
    endtask
    task automatic period(input int exp);
        realtime t0;
        @(posedge commonPhaseOut);
        t0 = $realtime;
        @(posedge commonPhaseOut);
        chk(80'(int'(($realtime - t0) / 5.0)), 80'(exp));
    endtask
    task automatic conclude();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================================
    // tests
    initial
    begin
        repeat (5) @(posedge clock);
        chk(80'({backplaneFirst, segmentOutputs[3:0]}), 80'h0);
        nrst <= 1'h1;
        apb(1'h1, 12'h000, 32'h0000_0003);
        apb(1'h0, 12'h000, 32'h0000_0000);
        chk(80'(rd), 80'h3);
        apb(1'h1, 12'h000, 32'h0000_0000);
        apb(1'h0, 12'h008, 32'h0000_0000);
        chk(80'({er, rd}), 80'h1_0000_0000);
        $display("test registers done");
        pat = {{4{20'hC_35A6}}, {4{20'h0_F96E}}};
        u_host.send(pat, 80);
        chk(80'(cascadeOutHalf), 80'(pat[79]));
        u_host.load();
        period(8 * 2 * OSCH);
        settle();
        chk(segmentOutputs, sx(pat[79:0]));
        chk(80'({backplaneFirst, backplaneSecond}), 80'({lv(), lv()}));
        u_host.send(~pat, 80);
        chk(80'({cascadeOutFull, cascadeOutHalf}), 80'({pat[79], ~pat[79]}));
        settle();
        chk(segmentOutputs, sx(pat[79:0]));
        allOnTest <= 1'h1;
        allOff <= 1'h1;
        settle();
        chk(segmentOutputs, sx({80{1'h1}}));
        allOnTest <= 1'h0;
        settle();
        chk(segmentOutputs, sx(80'h0));
        allOff <= 1'h0;
        settle();
        chk(segmentOutputs, sx(pat[79:0]));
        commonSourceSelect <= 1'h1;
        settle();
        chk(segmentOutputs, pat[79:0]);
        oscillatorInput <= 1'h1;
        settle();
        chk({commonPhaseOut, segmentOutputs[78:0]}, {1'h1, ~pat[78:0]});
        commonSourceSelect <= 1'h0;
        oscillatorInput <= 1'h0;
        $display("test static done");
        dutySelect <= 1'h1;
        u_host.send(pat, 160);
        chk(80'({cascadeOutFull, cascadeOutHalf}), 80'({pat[159], pat[79]}));
        u_host.load();
        period(4 * 2 * OSCH);
        seen = 2'h0;
        repeat (6)
        begin
            settle();
            sel2 = (backplaneFirst === sld_pkg::SLD_LVL_MID);
            seen[sel2] = 1'h1;
            chk(80'({backplaneFirst, backplaneSecond}), 80'(sel2 ? {sld_pkg::SLD_LVL_MID, lv()}
                : {lv(), sld_pkg::SLD_LVL_MID}));
            chk(segmentOutputs, sx(sel2 ? pat[159:80] : pat[79:0]));
        end
        chk(80'(seen), 80'h3);
        apb(1'h0, 12'h004, 32'h0000_0000);
        chk(80'(rd & 32'h0000_0033), 80'h21);
        $display("test half duty done");
        conclude();
    end
    // watchdog well beyond the roughly 9000 cycles the tests take
    initial
    begin
        repeat (60000) @(posedge clock);
        mismatches++;
        conclude();
    end
endmodule // segment_lcd_serial_driver_tb
`default_nettype wire
